// *** rtl/gstc_timer.v ***
// top of the gated 16-bit timer/counter with its register port
// assumes inputs other than the external clock sources synchronous to i_clk; reads answer next cycle
`include "gstc_regs.vh"
`default_nettype none
module gstc_timer (
  // clock, reset, enable
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_clk_en,
  // register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rd_data,
  // clock sources
  input  wire       i_ext_clock_pin,
  input  wire       i_crystal_clock,
  input  wire       i_secondary_digital_clock_pin,
  input  wire       i_osc_drive_crystal,
  // gate sources
  input  wire       i_gate_pin,
  input  wire       i_second_timer_match,
  input  wire       i_comparator_one,
  input  wire       i_comparator_two,
  // oscillator requests from outside the block
  input  wire       i_timer_three_osc_enable,
  input  wire       i_oscillator_warmup_request,
  input  wire [1:0] i_system_clock_select,
  // status outputs
  output reg [15:0] o_count,
  output reg        o_overflow_irq,
  output reg        o_osc_run,
  output reg        o_crystal_pins_input,
  output reg        o_port_read_zero
);
  //****************************************************************
  // registers and state
  //****************************************************************
  reg  [7:0] ctrl;
  reg  [7:0] gctrl;
  reg  [7:0] high_buf;
  reg        ovf_flag;
  reg        ovf_ie;
  reg  [1:0] div_cnt;
  reg  [2:0] ps_cnt;
  reg        armed;
  reg        on_prev;
  reg        gate_src;
  reg  [7:0] rd_mux;
  wire [1:0] src_sel;
  wire [1:0] ps_sel;
  wire [1:0] gs_sel;
  wire       timer_on;
  wire       wide;
  wire       sync_dis;
  wire       osc_en;
  wire       gate;
  wire       sp_done;
  wire       ext_rise;
  wire       ext_fall;
  wire       ext_sig;
  wire       wr_low;
  wire       wr_high;
  wire       wr_count;
  wire       rd_low;
  wire       src_tick;
  wire       ps_last;
  wire       inc_tick;
  wire       count_en;
  wire       inc;
  wire       gated_ok;

  // last prescaler count for a ratio code
  function [2:0] ps_limit;
    input [1:0] code;
    begin
      case (code)
        2'b00:   ps_limit = 3'h0;
        2'b01:   ps_limit = 3'h1;
        2'b10:   ps_limit = 3'h3;
        default: ps_limit = 3'h7;
      endcase
    end
  endfunction

  // register field views
  assign src_sel  = ctrl[`GSTC_C_CS_HI:`GSTC_C_CS_LO];
  assign ps_sel   = ctrl[`GSTC_C_PS_HI:`GSTC_C_PS_LO];
  assign osc_en   = ctrl[`GSTC_C_OSCEN];
  assign sync_dis = ctrl[`GSTC_C_SYNCDIS];
  assign wide     = ctrl[`GSTC_C_WIDE];
  assign timer_on = ctrl[`GSTC_C_ON];
  assign gs_sel   = gctrl[`GSTC_G_SS_HI:`GSTC_G_SS_LO];

  // register port decode
  assign wr_low   = i_wr && (i_addr == `GSTC_A_LOW);
  assign wr_high  = i_wr && (i_addr == `GSTC_A_HIGH);
  assign wr_count = wr_low || wr_high;
  assign rd_low   = i_rd && (i_addr == `GSTC_A_LOW);

  //****************************************************************
  // clock source selection
  //****************************************************************

  // external path: pin, or oscillator output by drive configuration
  assign ext_sig = !osc_en ? i_ext_clock_pin :
                   (i_osc_drive_crystal ? i_crystal_clock :
                    i_secondary_digital_clock_pin);

  // sync or bypass and edge detection of the external clock
  gstc_edge_sync u_ext (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_sig     (ext_sig),
    .i_bypass  (sync_dis),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );

  // source tick: undefined code 11 gives no ticks
  assign src_tick =
    (src_sel == `GSTC_SRC_INSTR) ? (div_cnt == `GSTC_INSTR_LAST) :
    (src_sel == `GSTC_SRC_SYS)   ? 1'b1 :
    (src_sel == `GSTC_SRC_EXT)   ? (ext_rise && armed) :
    1'b0;

  // prescaler output and the gated increment
  assign ps_last  = (ps_cnt == ps_limit(ps_sel));
  assign inc_tick = src_tick && ps_last;
  assign gated_ok = gctrl[`GSTC_G_GE] ? gate : 1'b1;
  assign count_en = timer_on && gated_ok;
  assign inc      = inc_tick && count_en;

  //****************************************************************
  // gate source and conditioning
  //****************************************************************

  // registered gate source mux
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      gate_src <= 1'b0;
    end else if (i_clk_en) begin
      case (gs_sel)
        `GSTC_GS_PIN:     gate_src <= i_gate_pin;
        `GSTC_GS_T2MATCH: gate_src <= i_second_timer_match;
        `GSTC_GS_CMP1:    gate_src <= i_comparator_one;
        default:          gate_src <= i_comparator_two;
      endcase
    end
  end

  // polarity, toggle and single-pulse logic
  gstc_gate u_gate (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_src     (gate_src),
    .i_pol     (gctrl[`GSTC_G_POL]),
    .i_toggle  (gctrl[`GSTC_G_TM]),
    .i_spm     (gctrl[`GSTC_G_SPM]),
    .i_go      (gctrl[`GSTC_G_GO]),
    .o_gate    (gate),
    .o_done    (sp_done)
  );

  //****************************************************************
  // dividers and external edge arming
  //****************************************************************

  // instruction clock divider and prescaler
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt <= 2'h0;
      ps_cnt  <= 3'h0;
    end else if (i_clk_en) begin
      div_cnt <= div_cnt + 2'h1;
      if (wr_low)
        ps_cnt <= 3'h0;
      else if (src_tick && timer_on)
        ps_cnt <= ps_last ? 3'h0 : ps_cnt + 3'h1;
    end
  end

  // falling edge must precede the first counted rise
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      armed   <= 1'b0;
      on_prev <= 1'b0;
    end else if (i_clk_en) begin
      on_prev <= timer_on;
      if (!timer_on || !on_prev || wr_count)
        armed <= 1'b0;
      else if (ext_fall)
        armed <= 1'b1;
    end
  end

  //****************************************************************
  // count pair, buffer, control registers
  //****************************************************************

  // count pair with byte or buffered wide access
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_count  <= `GSTC_RST_CNT;
      high_buf <= `GSTC_RST_BYTE;
    end else if (i_clk_en) begin
      if (wr_low) begin
        o_count[7:0] <= i_wr_data;
        if (wide)
          o_count[15:8] <= high_buf;
      end else if (wr_high) begin
        if (wide)
          high_buf <= i_wr_data;
        else
          o_count[15:8] <= i_wr_data;
      end else if (inc) begin
        o_count <= o_count + 16'h0001;
      end
      if (rd_low && wide)
        high_buf <= o_count[15:8];
    end
  end

  // control, gate control and status registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl     <= `GSTC_RST_BYTE;
      gctrl    <= `GSTC_RST_BYTE;
      ovf_flag <= 1'b0;
      ovf_ie   <= 1'b0;
    end else if (i_clk_en) begin
      if (i_wr && (i_addr == `GSTC_A_CTRL))
        ctrl <= i_wr_data;
      if (i_wr && (i_addr == `GSTC_A_GCTRL)) begin
        gctrl[7:4] <= i_wr_data[7:4];
        gctrl[`GSTC_G_SS_HI:`GSTC_G_SS_LO] <=
          i_wr_data[`GSTC_G_SS_HI:`GSTC_G_SS_LO];
        gctrl[`GSTC_G_GO] <= i_wr_data[`GSTC_G_GO] &&
                             i_wr_data[`GSTC_G_SPM];
      end else if (!gctrl[`GSTC_G_SPM] || sp_done) begin
        gctrl[`GSTC_G_GO] <= 1'b0;
      end
      gctrl[`GSTC_G_VAL] <= 1'b0;
      if (i_wr && (i_addr == `GSTC_A_STAT)) begin
        ovf_ie   <= i_wr_data[`GSTC_S_IE];
        ovf_flag <= i_wr_data[`GSTC_S_OVF];
      end
      if (inc && (o_count == `GSTC_CNT_MAX) && !wr_count)
        ovf_flag <= 1'b1;
    end
  end

  //****************************************************************
  // read data and status outputs
  //****************************************************************

  // read mux; unmapped indices read zero
  always @* begin
    rd_mux = 8'h00;
    case (i_addr)
      `GSTC_A_LOW:  rd_mux = o_count[7:0];
      `GSTC_A_HIGH: rd_mux = wide ? high_buf : o_count[15:8];
      `GSTC_A_CTRL: rd_mux = ctrl;
      `GSTC_A_GCTRL: begin
        rd_mux = gctrl;
        rd_mux[`GSTC_G_VAL] = gate;
        rd_mux[`GSTC_G_GO]  = gctrl[`GSTC_G_GO];
      end
      `GSTC_A_STAT: begin
        rd_mux[`GSTC_S_OVF] = ovf_flag;
        rd_mux[`GSTC_S_IE]  = ovf_ie;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // registered read data and side outputs
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data            <= `GSTC_RST_BYTE;
      o_overflow_irq       <= 1'b0;
      o_osc_run            <= 1'b0;
      o_crystal_pins_input <= 1'b0;
      o_port_read_zero     <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_data <= i_rd ? rd_mux : `GSTC_RST_BYTE;
      o_overflow_irq <= ovf_flag && ovf_ie;
      o_osc_run <= osc_en || i_timer_three_osc_enable ||
                   i_oscillator_warmup_request ||
                   (i_system_clock_select == `GSTC_SCS_SECONDARY_OSCILLATOR);
      o_crystal_pins_input <= i_osc_drive_crystal;
      o_port_read_zero     <= i_osc_drive_crystal;
    end
  end
endmodule
`default_nettype wire

// *** rtl/gstc_regs.vh ***
// constants of the gated 16-bit timer/counter: map, fields, codes
// assumes inclusion by the top design file, the checker and the bench
`ifndef GSTC_REGS_VH
`define GSTC_REGS_VH
// register indices on the plain register port
`define GSTC_ADDR_W      4
`define GSTC_A_LOW       4'h0
`define GSTC_A_HIGH      4'h1
`define GSTC_A_CTRL      4'h2
`define GSTC_A_GCTRL     4'h3
`define GSTC_A_STAT      4'h4
// timer_one_control fields
`define GSTC_C_CS_HI     7
`define GSTC_C_CS_LO     6
`define GSTC_C_PS_HI     5
`define GSTC_C_PS_LO     4
`define GSTC_C_OSCEN     3
`define GSTC_C_SYNCDIS   2
`define GSTC_C_WIDE      1
`define GSTC_C_ON        0
// timer_one_gate_control fields
`define GSTC_G_GE        7
`define GSTC_G_POL       6
`define GSTC_G_TM        5
`define GSTC_G_SPM       4
`define GSTC_G_GO        3
`define GSTC_G_VAL       2
`define GSTC_G_SS_HI     1
`define GSTC_G_SS_LO     0
// status fields
`define GSTC_S_OVF       0
`define GSTC_S_IE        1
// reset values
`define GSTC_RST_BYTE    8'h00
`define GSTC_RST_CNT     16'h0000
// clock source codes
`define GSTC_SRC_INSTR   2'b00
`define GSTC_SRC_SYS     2'b01
`define GSTC_SRC_EXT     2'b10
// gate source codes
`define GSTC_GS_PIN      2'b00
`define GSTC_GS_T2MATCH  2'b01
`define GSTC_GS_CMP1     2'b10
`define GSTC_GS_CMP2     2'b11
// system clock select code for the secondary oscillator
`define GSTC_SCS_SECONDARY_OSCILLATOR    2'b01
// instruction clock is the system clock divided by four
`define GSTC_INSTR_LAST  2'h3
// count roll-over value
`define GSTC_CNT_MAX     16'hffff
`endif

// *** rtl/gstc_edge_sync.v ***
// external clock conditioning: optional two-stage sync, edge detect
// assumes the input is sampled on i_clk; bypass skips one stage
`default_nettype none
module gstc_edge_sync (
  // clock, reset, enable
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_clk_en,
  // signal and mode
  input  wire i_sig,
  input  wire i_bypass,
  // detected edges
  output wire o_rise,
  output wire o_fall
);
  reg meta;
  reg sync_q;
  reg raw_q;
  reg prev;
  wire level;

  // first stage feeds only the second stage
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta   <= 1'b0;
      sync_q <= 1'b0;
      raw_q  <= 1'b0;
      prev   <= 1'b0;
    end else if (i_clk_en) begin
      meta   <= i_sig;
      sync_q <= meta;
      raw_q  <= i_sig;
      prev   <= level;
    end
  end

  // chosen level and its edges
  assign level  = i_bypass ? raw_q : sync_q;
  assign o_rise = level & ~prev;
  assign o_fall = ~level & prev;
endmodule
`default_nettype wire

// *** rtl/gstc_gate.v ***
// gate conditioning: polarity, toggle flip-flop, single-pulse control
// assumes the selected gate source is synchronous to i_clk
`default_nettype none
module gstc_gate (
  // clock, reset, enable
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_clk_en,
  // gate source and mode bits
  input  wire i_src,
  input  wire i_pol,
  input  wire i_toggle,
  input  wire i_spm,
  input  wire i_go,
  // conditioned gate and completion pulse
  output reg  o_gate,
  output reg  o_done
);
  localparam SP_IDLE  = 2'd0;
  localparam SP_WAIT  = 2'd1;
  localparam SP_PULSE = 2'd2;

  reg [1:0] sp_state;
  reg [1:0] next_sp_state;
  reg       pol_prev;
  reg       tff;
  reg       base_prev;
  reg       next_gate;
  reg       next_done;
  wire      pol_sig;
  wire      base;
  wire      base_rise;

  // polarity and toggle selection
  assign pol_sig   = i_pol ? i_src : ~i_src;
  assign base      = i_toggle ? tff : pol_sig;
  assign base_rise = base & ~base_prev;

  // single-pulse sequencing and the gate it offers
  always @* begin
    next_sp_state = sp_state;
    next_done     = 1'b0;
    next_gate     = base;
    case (sp_state)
      SP_IDLE: begin
        if (i_spm && i_go)
          next_sp_state = SP_WAIT;
      end
      SP_WAIT: begin
        if (!i_spm || !i_go)
          next_sp_state = SP_IDLE;
        else if (base_rise)
          next_sp_state = SP_PULSE;
      end
      SP_PULSE: begin
        if (!i_spm) begin
          next_sp_state = SP_IDLE;
        end else if (!base) begin
          next_sp_state = SP_IDLE;
          next_done     = 1'b1;
        end
      end
      default: next_sp_state = SP_IDLE;
    endcase
    if (i_spm)
      next_gate = ((sp_state == SP_WAIT) && i_go && base_rise) ||
                  ((sp_state == SP_PULSE) && base);
  end

  // state, toggle flip-flop and registered gate
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_state  <= SP_IDLE;
      pol_prev  <= 1'b0;
      tff       <= 1'b0;
      base_prev <= 1'b0;
      o_gate    <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_clk_en) begin
      sp_state  <= next_sp_state;
      pol_prev  <= pol_sig;
      base_prev <= base;
      o_gate    <= next_gate;
      o_done    <= next_done;
      if (!i_toggle)
        tff <= 1'b0;
      else if (pol_sig && !pol_prev)
        tff <= ~tff;
    end
  end
endmodule
`default_nettype wire

// *** dv/gstc_timer_props.sv ***
// checker for the gated timer: count steps, read port, oscillator outputs
// assumes it sees only the top ports; the bind sits at the foot
`include "gstc_regs.vh"
`default_nettype none
module gstc_timer_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_clk_en,
  // register port
  input wire logic [3:0]  i_addr,
  input wire logic [7:0]  i_wr_data,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rd_data,
  // sources and status
  input wire logic        i_gate_pin,
  input wire logic        i_osc_drive_crystal,
  input wire logic        i_timer_three_osc_enable,
  input wire logic        i_oscillator_warmup_request,
  input wire logic [1:0]  i_system_clock_select,
  input wire logic [15:0] o_count,
  input wire logic        o_osc_run,
  input wire logic        o_crystal_pins_input,
  input wire logic        o_port_read_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // register shadows and helper flags
  // ************************************************************
  logic [7:0] ctl;
  logic [7:0] gcl;
  logic       ok;    // previous edge was live, out of reset
  logic       cw;    // write to a count byte
  logic       shut;  // pin gate enabled and inactive
  // count writes and an inactive pin gate
  assign cw = i_clk_en && i_wr && i_addr <= `GSTC_A_HIGH;
  assign shut = gcl[7] && !gcl[5] && !gcl[4] && gcl[1:0] == 2'b00
                && i_gate_pin != gcl[6];
  // follow control writes; ok masks edges that see reset history
  always_ff @(posedge i_clk) begin
    ok <= !i_sys_rst && i_clk_en;
    if (i_sys_rst) begin
      ctl <= 8'h00;
      gcl <= 8'h00;
    end else if (i_clk_en && i_wr && i_addr == `GSTC_A_CTRL) begin
      ctl <= i_wr_data;
    end else if (i_clk_en && i_wr && i_addr == `GSTC_A_GCTRL) begin
      gcl <= i_wr_data;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // gate path needs four quiet live cycles to settle inactive
  sequence s_shut4;
    (shut && !cw && i_clk_en)[*4];
  endsequence
  // ************************************************************
  // properties
  // ************************************************************
  AST_RD_LOW:
    assert property (ok && $past(i_rd && i_addr == `GSTC_A_LOW)
      |-> o_rd_data == $past(o_count[7:0])) else $error("low read wrong");
  AST_HOLD_OFF:
    assert property (ok && $past(!ctl[0] && !cw) |-> $stable(o_count))
      else $error("count moved while off");
  AST_STEP:
    assert property (ok && !$past(cw) && $changed(o_count)
      |-> o_count == $past(o_count) + 16'h0001) else $error("bad step");
  AST_SYS_RATE:
    assert property (ok && $past(ctl == 8'h41 && !gcl[7] && !cw)
      |-> o_count == $past(o_count) + 16'h0001) else $error("missed tick");
  AST_GATE_HOLD:
    assert property (s_shut4 |=> $stable(o_count))
      else $error("count moved with gate inactive");
  AST_GO_CLR:
    assert property (ok && $past(i_rd && i_addr == `GSTC_A_GCTRL && !gcl[4])
      |-> !o_rd_data[3]) else $error("go set without single pulse");
  AST_OSC_RUN:
    assert property (ok |-> o_osc_run == $past(ctl[3]
      || i_timer_three_osc_enable || i_oscillator_warmup_request
      || i_system_clock_select == `GSTC_SCS_SECONDARY_OSCILLATOR)) else $error("osc run");
  AST_XTAL:
    assert property (ok |-> o_port_read_zero == $past(i_osc_drive_crystal)
      && o_crystal_pins_input == $past(i_osc_drive_crystal))
      else $error("crystal pin state wrong");
endmodule
bind gstc_timer gstc_timer_props u_props (.i_clk, .i_sys_rst, .i_clk_en,
  .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_gate_pin,
  .i_osc_drive_crystal, .i_timer_three_osc_enable,
  .i_oscillator_warmup_request, .i_system_clock_select, .o_count,
  .o_osc_run, .o_crystal_pins_input, .o_port_read_zero);
`default_nettype wire

// *** dv/gstc_far_model.sv ***
// far side: external clock pin and crystal output, driven in bursts
// assumes the bench calls burst; both clocks rest low between bursts
`default_nettype none
module gstc_far_model (
  // bench clock
  input  wire logic i_clk,
  // clocks offered to the timer
  output var  logic o_ext_clock,
  output var  logic o_crystal_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // clock bursts
  // ************************************************************
  initial begin
    o_ext_clock = 1'b0;
    o_crystal_clock = 1'b0;
  end
  // n pulses of eight system clocks, each starting from low
  task automatic burst(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk);
      o_ext_clock <= 1'b1;
      o_crystal_clock <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ext_clock <= 1'b0;
      o_crystal_clock <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the gated timer over its register port
// assumes the far-side model supplies external and crystal clocks
`include "gstc_regs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
  // ************************************************************
  // stimulus, instances and access tasks
  // ************************************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdat = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  gsrc = 4'hf;  // comparator two, one, match, pin
  logic [3:0]  osrc = 4'h0;  // timer three, warm-up, clock select
  logic        xcfg = 1'b0;
  logic [7:0]  rdat;
  logic [7:0]  d;
  logic [15:0] cnt;
  logic        irq;
  logic        ext_ck;
  logic        xtal_ck;
  int          errors = 0;
  int          checks = 0;
  int          i;
  logic [7:0]  rate_c [7] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'h31,
                              8'hc1};
  logic [15:0] rate_e [7] = '{80, 40, 20, 10, 20, 2, 0};
  logic [7:0]  ext_c [5] = '{8'h81, 8'h85, 8'h89, 8'h89, 8'h89};
  logic [15:0] ext_e [5] = '{4, 4, 4, 0, 4};
  initial forever #20 clk = ~clk;
  gstc_far_model u_far (.i_clk(clk), .o_ext_clock(ext_ck),
    .o_crystal_clock(xtal_ck));
  gstc_timer uut (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(ce),
    .i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rdat), .i_ext_clock_pin(ext_ck), .i_crystal_clock(xtal_ck),
    .i_secondary_digital_clock_pin(ext_ck & (i == 4)),
    .i_osc_drive_crystal(xcfg),
    .i_gate_pin(gsrc[0]), .i_second_timer_match(gsrc[1]),
    .i_comparator_one(gsrc[2]), .i_comparator_two(gsrc[3]),
    .i_timer_three_osc_enable(osrc[3]),
    .i_oscillator_warmup_request(osrc[2]),
    .i_system_clock_select(osrc[1:0]), .o_count(cnt),
    .o_overflow_irq(irq), .o_osc_run(), .o_crystal_pins_input(),
    .o_port_read_zero());
  // one write cycle; returns just after the edge that takes it
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // one read cycle; data stand only in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdat;
  endtask
  // timer on for exactly k edges, then off again
  task automatic run(input logic [7:0] c, input int k);
    wr_reg(`GSTC_A_CTRL, c);
    repeat (k - 2) @(posedge clk);
    wr_reg(`GSTC_A_CTRL, c & 8'hfe);
  endtask
  task automatic clr();
    wr_reg(`GSTC_A_HIGH, 8'h00);
    wr_reg(`GSTC_A_LOW, 8'h00);
  endtask
  task automatic chk_cnt(input logic [15:0] e);
    rd_reg(`GSTC_A_LOW, d);
    `CHK(d, e[7:0])
    rd_reg(`GSTC_A_HIGH, d);
    `CHK(d, e[15:8])
  endtask
  // high pulse of n cycles on the gate pin, then settle
  task automatic pulse(input int n);
    @(posedge clk);
    gsrc[0] <= 1'b1;
    repeat (n) @(posedge clk);
    gsrc[0] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped index; gate value bit masked
    for (i = 0; i < 6; i++) begin
      rd_reg(i[3:0], d);
      `CHK(d & ((i == 3) ? 8'hfb : 8'hff), 8'h00)
    end
    // clock sources and prescale ratios
    for (i = 0; i < 7; i++) begin
      clr();
      run(rate_c[i], 80);
      chk_cnt(rate_e[i]);
    end
    // clock enable low freezes the count of a running timer
    clr();
    wr_reg(`GSTC_A_CTRL, 8'h41);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wr_reg(`GSTC_A_CTRL, 8'h40);
    chk_cnt(16'd2);
    // prescaler kept by high writes, cleared by low writes
    wr_reg(`GSTC_A_CTRL, 8'h70);
    clr();
    run(8'h71, 4);
    wr_reg(`GSTC_A_HIGH, 8'h00);
    run(8'h71, 4);
    chk_cnt(16'h0001);
    run(8'h71, 4);
    wr_reg(`GSTC_A_LOW, 8'h00);
    run(8'h71, 4);
    chk_cnt(16'h0000);
    // byte access, then buffered wide access
    wr_reg(`GSTC_A_CTRL, 8'h00);
    wr_reg(`GSTC_A_HIGH, 8'h12);
    wr_reg(`GSTC_A_LOW, 8'h34);
    chk_cnt(16'h1234);
    wr_reg(`GSTC_A_CTRL, 8'h02);
    wr_reg(`GSTC_A_HIGH, 8'h56);
    `CHK(cnt, 16'h1234)
    wr_reg(`GSTC_A_LOW, 8'h78);
    `CHK(cnt, 16'h5678)
    wr_reg(`GSTC_A_HIGH, 8'h9a);
    rd_reg(`GSTC_A_LOW, d);
    `CHK(d, 8'h78)
    rd_reg(`GSTC_A_HIGH, d);
    `CHK(d, 8'h56)
    // every gate source under both polarities and both levels
    for (i = 0; i < 16; i++) begin
      gsrc <= i[0] ? (4'h1 << i[3:2]) : ~(4'h1 << i[3:2]);
      wr_reg(`GSTC_A_GCTRL, {1'b1, i[1], 4'h0, i[3:2]});
      clr();
      run(8'h41, 20);
      chk_cnt((i[0] == i[1]) ? 16'd20 : 16'd0);
      rd_reg(`GSTC_A_GCTRL, d);
      `CHK(d[2], i[0] == i[1])
    end
    gsrc <= 4'h0;
    wr_reg(`GSTC_A_GCTRL, 8'h40);
    clr();
    run(8'h41, 20);
    chk_cnt(16'd20);
    // toggle flip-flop cleared by leaving toggle mode
    wr_reg(`GSTC_A_GCTRL, 8'he0);
    clr();
    pulse(3);
    wr_reg(`GSTC_A_GCTRL, 8'hc0);
    wr_reg(`GSTC_A_GCTRL, 8'he0);
    run(8'h41, 20);
    chk_cnt(16'd0);
    pulse(3);
    run(8'h41, 20);
    chk_cnt(16'd20);
    // single pulse: one gate pulse counted, go drops, second ignored
    wr_reg(`GSTC_A_GCTRL, 8'hd8);
    clr();
    rd_reg(`GSTC_A_GCTRL, d);
    `CHK(d[3], 1'b1)
    wr_reg(`GSTC_A_CTRL, 8'h41);
    pulse(10);
    rd_reg(`GSTC_A_GCTRL, d);
    `CHK(d[3], 1'b0)
    pulse(10);
    wr_reg(`GSTC_A_CTRL, 8'h40);
    chk_cnt(16'd10);
    wr_reg(`GSTC_A_GCTRL, 8'h18);
    wr_reg(`GSTC_A_GCTRL, 8'h08);
    rd_reg(`GSTC_A_GCTRL, d);
    `CHK(d[3], 1'b0)
    // roll-over sets the flag and, enabled, the interrupt
    wr_reg(`GSTC_A_GCTRL, 8'h00);
    wr_reg(`GSTC_A_HIGH, 8'hff);
    wr_reg(`GSTC_A_LOW, 8'hfe);
    wr_reg(`GSTC_A_STAT, 8'h02);
    run(8'h41, 3);
    chk_cnt(16'h0001);
    rd_reg(`GSTC_A_STAT, d);
    `CHK(d, 8'h03)
    `CHK(irq, 1'b1)
    wr_reg(`GSTC_A_STAT, 8'h02);
    rd_reg(`GSTC_A_STAT, d);
    `CHK(d, 8'h02)
    `CHK(irq, 1'b0)
    // external pin, unsynchronised, crystal, idle and live digital paths
    for (i = 0; i < 5; i++) begin
      xcfg <= (i == 2);
      clr();
      wr_reg(`GSTC_A_CTRL, ext_c[i]);
      u_far.burst(5);
      repeat (8) @(posedge clk);
      wr_reg(`GSTC_A_CTRL, 8'h00);
      chk_cnt(ext_e[i]);
    end
    // every oscillator request combination
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      osrc <= i[3:0];
    end
    repeat (4) @(posedge clk);
    finish_test();
  end
  // guard against a hang
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
